// [common/csr_pkg.sv]
package csr_pkg;
  localparam logic [7:0] CSR_STATUS_ADDR  = 8'h03;
  localparam int         CSR_WAKE_BIT     = 7;
  localparam int         CSR_PAGE_BIT     = 5;
  localparam int         CSR_TO_BIT       = 4;
  localparam int         CSR_PD_BIT       = 3;
  localparam int         CSR_Z_BIT        = 2;
  localparam int         CSR_DC_BIT       = 1;
  localparam int         CSR_C_BIT        = 0;
  localparam logic [7:0] CSR_OPTION_RESET = 8'hff;
  localparam int         CSR_PAGE_WORDS   = 512;
  localparam logic [9:0] CSR_PAGE1_BASE   = 10'h200;
  localparam logic [9:0] CSR_PAGE0_BASE   = 10'h000;
  localparam int         CSR_NUM_PINS     = 6;

  typedef enum logic [2:0] {
    CSR_OP_NONE, CSR_OP_ADD, CSR_OP_SUB, CSR_OP_LOGIC, CSR_OP_RRF, CSR_OP_RLF
  } csr_alu_op_t;

  typedef struct packed {
    logic wake_n;
    logic pullup_n;
    logic clk_sel;
    logic edge_sel;
    logic prescaler_assign;
    logic [2:0] rate;
  } csr_option_t;

  typedef struct packed {
    csr_alu_op_t op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic        c_in;
  } csr_alu_req_t;
endpackage

// [hdl/csr_option_decode.sv]
`timescale 1ns/10ps
module csr_option_decode
  import csr_pkg::*;
#(
  parameter int NUM_PINS = CSR_NUM_PINS
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire csr_option_t         opt,
  input  wire logic [NUM_PINS-1:0] dir_in,
  input  wire logic [NUM_PINS-1:0] wake_capable,
  input  wire logic [NUM_PINS-1:0] tck_pin_mask,
  output logic      [NUM_PINS-1:0] wake_en_q,
  output logic      [NUM_PINS-1:0] pullup_en_q,
  output logic      [NUM_PINS-1:0] dir_eff_q,
  output logic      [7:0]          tmr_ratio_q,
  output logic      [7:0]          wdt_ratio_q
);
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          wake_en_q[i]   <= 1'b0;
          pullup_en_q[i] <= 1'b0;
          dir_eff_q[i]   <= 1'b1;
        end else begin
          // output pins lose wake and pull-up
          wake_en_q[i]   <= wake_capable[i] & ~opt.wake_n & dir_in[i];
          pullup_en_q[i] <= wake_capable[i] & ~opt.pullup_n & dir_in[i];
          // external timer clock pin forced to input
          dir_eff_q[i]   <= dir_in[i] | (tck_pin_mask[i] & opt.clk_sel);
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr_ratio_q <= 8'h00;
      wdt_ratio_q <= 8'h00;
    end else begin
      // ratio minus one; timer 2<<rate, watchdog 1<<rate
      tmr_ratio_q <= 8'((9'h002 << opt.rate) - 9'h001);
      wdt_ratio_q <= 8'((9'h001 << opt.rate) - 9'h001);
    end
  end
endmodule

// [hdl/csr_core_regs.sv]
`timescale 1ns/10ps
module csr_core_regs
  import csr_pkg::*;
#(
  parameter int NUM_PINS = CSR_NUM_PINS
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                por_event,
  input  wire logic                wake_reset_event,
  input  wire logic                wdt_timeout,
  input  wire logic                watchdog_clear_instr_exec,
  input  wire logic                sleep_exec,
  input  wire csr_alu_req_t        alu_req,
  input  wire logic [7:0]          alu_result,
  input  wire logic                file_wr,
  input  wire logic [7:0]          file_addr,
  input  wire logic [7:0]          file_wdata,
  input  wire logic                option_load,
  input  wire logic [7:0]          w_reg,
  input  wire logic [NUM_PINS-1:0] dir_in,
  input  wire logic [NUM_PINS-1:0] wake_capable,
  input  wire logic [NUM_PINS-1:0] tck_pin_mask,
  input  wire logic                tck_pin,
  output logic      [7:0]          status_q,
  output logic      [9:0]          page_base_q,
  output logic      [NUM_PINS-1:0] wake_en_q,
  output logic      [NUM_PINS-1:0] pullup_en_q,
  output logic      [NUM_PINS-1:0] dir_eff_q,
  output logic                     tmr_tick_q,
  output logic                     psa_wdt_q,
  output logic      [7:0]          tmr_ratio_q,
  output logic      [7:0]          wdt_ratio_q
);
  logic        wake_flag_q;
  logic        page_q;
  logic        to_q;
  logic        pd_q;
  logic        z_q;
  logic        dc_q;
  logic        c_q;
  csr_option_t opt_q;
  logic        tck_s1_q;
  logic        tck_s2_q;
  logic        tck_s3_q;
  logic        iclk_q;
  logic        status_wr;
  logic        alu_flags;
  logic [8:0]  sum9;
  logic [4:0]  sum5;

  assign status_wr = file_wr && (file_addr == CSR_STATUS_ADDR);
  assign alu_flags = (alu_req.op != CSR_OP_NONE);
  assign sum9 = (alu_req.op == CSR_OP_SUB) ? ({1'b0, alu_req.a} + {1'b0, ~alu_req.b} + 9'h001)
                                           : ({1'b0, alu_req.a} + {1'b0, alu_req.b});
  assign sum5 = (alu_req.op == CSR_OP_SUB) ? ({1'b0, alu_req.a[3:0]} + {1'b0, ~alu_req.b[3:0]}
                                              + 5'h01)
                                           : ({1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]});

  // reset-cause flag, caught synchronously after reset events
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_flag_q <= 1'b0;
    end else if (wake_reset_event) begin
      wake_flag_q <= 1'b1;
    end else if (por_event) begin
      wake_flag_q <= 1'b0;
    end else if (status_wr) begin
      wake_flag_q <= file_wdata[CSR_WAKE_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_q <= 1'b0;
    end else if (por_event) begin
      page_q <= 1'b0;
    end else if (status_wr) begin
      page_q <= file_wdata[CSR_PAGE_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_base_q <= CSR_PAGE0_BASE;
    end else begin
      page_base_q <= page_q ? CSR_PAGE1_BASE : CSR_PAGE0_BASE;
    end
  end

  // time-out flag; expiry wins over clear/sleep, writes ignored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      to_q <= 1'b1;
    end else if (wdt_timeout) begin
      to_q <= 1'b0;
    end else if (por_event || watchdog_clear_instr_exec || sleep_exec) begin
      to_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pd_q <= 1'b1;
    end else if (sleep_exec) begin
      pd_q <= 1'b0;
    end else if (por_event || watchdog_clear_instr_exec) begin
      pd_q <= 1'b1;
    end
  end

  // alu flags; any alu op (add, sub, logic, rotate) beats a status-destination write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      z_q <= 1'b0;
    end else if (alu_req.op inside {CSR_OP_ADD, CSR_OP_SUB, CSR_OP_LOGIC}) begin
      z_q <= (alu_result == 8'h00);
    end else if (status_wr && !alu_flags) begin
      z_q <= file_wdata[CSR_Z_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dc_q <= 1'b0;
    end else if (alu_req.op == CSR_OP_ADD || alu_req.op == CSR_OP_SUB) begin
      dc_q <= sum5[4];
    end else if (status_wr && !alu_flags) begin
      dc_q <= file_wdata[CSR_DC_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c_q <= 1'b0;
    end else begin
      unique case (alu_req.op)
        CSR_OP_ADD, CSR_OP_SUB: c_q <= sum9[8];
        CSR_OP_RRF:             c_q <= alu_req.a[0];
        CSR_OP_RLF:             c_q <= alu_req.a[7];
        CSR_OP_LOGIC:           c_q <= c_q;
        CSR_OP_NONE: begin
          if (status_wr) begin
            c_q <= file_wdata[CSR_C_BIT];
          end
        end
        default:                c_q <= c_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_q <= {1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'b000};
    end else begin
      status_q <= {wake_flag_q, 1'b0, page_q, to_q, pd_q, z_q, dc_q, c_q};
    end
  end

  // option register, no read path
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      opt_q <= csr_option_t'(CSR_OPTION_RESET);
    end else if (por_event || wake_reset_event) begin
      opt_q <= csr_option_t'(CSR_OPTION_RESET);
    end else if (option_load) begin
      opt_q <= csr_option_t'(w_reg);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      psa_wdt_q <= 1'b1;
    end else begin
      psa_wdt_q <= opt_q.prescaler_assign;
    end
  end

  // external clock pin synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
    end else begin
      tck_s1_q <= tck_pin;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
    end
  end

  // internal instruction-cycle tick, one per core_clk
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      iclk_q <= 1'b0;
    end else begin
      iclk_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr_tick_q <= 1'b0;
    end else if (opt_q.clk_sel) begin
      tmr_tick_q <= opt_q.edge_sel ? (tck_s3_q & ~tck_s2_q)
                                   : (~tck_s3_q & tck_s2_q);
    end else begin
      tmr_tick_q <= iclk_q;
    end
  end

  csr_option_decode #(
    .NUM_PINS (NUM_PINS)
  ) u_decode (
    .core_clk     (core_clk),
    .rst          (rst),
    .opt          (opt_q),
    .dir_in       (dir_in),
    .wake_capable (wake_capable),
    .tck_pin_mask (tck_pin_mask),
    .wake_en_q    (wake_en_q),
    .pullup_en_q  (pullup_en_q),
    .dir_eff_q    (dir_eff_q),
    .tmr_ratio_q  (tmr_ratio_q),
    .wdt_ratio_q  (wdt_ratio_q)
  );

  a_to_expiry: assert property (@(posedge core_clk) disable iff (rst)
    wdt_timeout |=> !to_q)
    else $error("time-out flag not cleared by expiry");
  a_to_set: assert property (@(posedge core_clk) disable iff (rst)
    (watchdog_clear_instr_exec && !wdt_timeout) |=> to_q)
    else $error("time-out flag not set");
  a_pd_sleep: assert property (@(posedge core_clk) disable iff (rst)
    sleep_exec |=> ##1 !status_q[CSR_PD_BIT])
    else $error("power-down flag not cleared");
  a_to_ro: assert property (@(posedge core_clk) disable iff (rst)
    (status_wr && !wdt_timeout && !por_event && !watchdog_clear_instr_exec && !sleep_exec) |=> $stable(to_q))
    else $error("time-out flag written");
  a_wake_flag: assert property (@(posedge core_clk) disable iff (rst)
    wake_reset_event |=> ##1 status_q[CSR_WAKE_BIT])
    else $error("wake flag missing");
  a_zero_flag: assert property (@(posedge core_clk) disable iff (rst)
    (alu_req.op == CSR_OP_LOGIC) |=> (z_q == ($past(alu_result) == 8'h00)))
    else $error("zero flag wrong");
  a_dc_add: assert property (@(posedge core_clk) disable iff (rst)
    (alu_req.op == CSR_OP_ADD) |=>
      (dc_q == (({1'b0, $past(alu_req.a[3:0])} + {1'b0, $past(alu_req.b[3:0])}) > 5'h0f)))
    else $error("digit carry wrong on add");
  a_dc_sub: assert property (@(posedge core_clk) disable iff (rst)
    (alu_req.op == CSR_OP_SUB) |=> (dc_q == ($past(alu_req.a[3:0]) >= $past(alu_req.b[3:0]))))
    else $error("digit borrow wrong on sub");
  a_c_rotate: assert property (@(posedge core_clk) disable iff (rst)
    (alu_req.op == CSR_OP_RLF) |=> (c_q == $past(alu_req.a[7])))
    else $error("carry wrong on rotate");
  a_opt_load: assert property (@(posedge core_clk) disable iff (rst)
    (option_load && !por_event && !wake_reset_event) |=> (opt_q == $past(w_reg)))
    else $error("option load lost");
  a_opt_reset: assert property (@(posedge core_clk) disable iff (rst)
    por_event |=> (opt_q == CSR_OPTION_RESET))
    else $error("option not reset");
  a_page_base: assert property (@(posedge core_clk) disable iff (rst)
    page_q |=> (page_base_q == CSR_PAGE1_BASE))
    else $error("page base wrong");
  a_pullup_dir: assert property (@(posedge core_clk) disable iff (rst)
    (dir_in == '0) |=> (pullup_en_q == '0) && (wake_en_q == '0))
    else $error("output pin kept pull-up");

  // remaining cause flags, alu flags, option register and timer tick
  a_to_por: assert property (@(posedge core_clk) disable iff (rst)
    (por_event && !wdt_timeout) |=> to_q)
    else $error("time-out flag not set by power-up");
  a_to_sleep: assert property (@(posedge core_clk) disable iff (rst)
    (sleep_exec && !wdt_timeout) |=> to_q)
    else $error("time-out flag not set by sleep");
  a_pd_watchdog_clear_instr: assert property (@(posedge core_clk) disable iff (rst)
    (watchdog_clear_instr_exec && !sleep_exec) |=> pd_q)
    else $error("power-down flag not set by clear");
  a_pd_ro: assert property (@(posedge core_clk) disable iff (rst)
    (status_wr && !por_event && !watchdog_clear_instr_exec && !sleep_exec) |=> $stable(pd_q))
    else $error("power-down flag written");
  a_wake_clear: assert property (@(posedge core_clk) disable iff (rst)
    (por_event && !wake_reset_event) |=> !wake_flag_q)
    else $error("wake flag not cleared by other reset");
  a_zero_arith: assert property (@(posedge core_clk) disable iff (rst)
    (alu_req.op inside {CSR_OP_ADD, CSR_OP_SUB}) |=> (z_q == ($past(alu_result) == 8'h00)))
    else $error("zero flag wrong on arithmetic");
  a_c_add: assert property (@(posedge core_clk) disable iff (rst)
    (alu_req.op == CSR_OP_ADD) |=>
      (c_q == (({1'b0, $past(alu_req.a)} + {1'b0, $past(alu_req.b)}) > 9'h0ff)))
    else $error("carry wrong on add");
  a_c_sub: assert property (@(posedge core_clk) disable iff (rst)
    (alu_req.op == CSR_OP_SUB) |=> (c_q == ($past(alu_req.a) >= $past(alu_req.b))))
    else $error("borrow wrong on sub");
  a_dc_guard: assert property (@(posedge core_clk) disable iff (rst)
    (status_wr && (alu_req.op inside {CSR_OP_LOGIC, CSR_OP_RRF, CSR_OP_RLF})) |=> $stable(dc_q))
    else $error("digit carry taken from status write");
  a_c_guard: assert property (@(posedge core_clk) disable iff (rst)
    (status_wr && (alu_req.op == CSR_OP_LOGIC)) |=> $stable(c_q))
    else $error("carry taken from status write");
  a_opt_hold: assert property (@(posedge core_clk) disable iff (rst)
    (!option_load && !por_event && !wake_reset_event) |=> $stable(opt_q))
    else $error("option changed without load");
  a_opt_wake: assert property (@(posedge core_clk) disable iff (rst)
    wake_reset_event |=> (opt_q == CSR_OPTION_RESET))
    else $error("option not reset by wake");
  a_psa_track: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> (psa_wdt_q == $past(opt_q.prescaler_assign)))
    else $error("prescaler owner wrong");
  a_int_tick: assert property (@(posedge core_clk) disable iff (rst)
    !opt_q.clk_sel |=> tmr_tick_q)
    else $error("internal tick missing");
  a_ext_edge: assert property (@(posedge core_clk) disable iff (rst)
    (opt_q.clk_sel && opt_q.edge_sel && tck_s3_q && !tck_s2_q) |=> tmr_tick_q)
    else $error("falling edge tick missing");

  c_sleep: cover property (@(posedge core_clk) disable iff (rst) sleep_exec);
  c_expiry: cover property (@(posedge core_clk) disable iff (rst) wdt_timeout);
  c_opt_load: cover property (@(posedge core_clk) disable iff (rst) option_load);
  c_ext_tick: cover property (@(posedge core_clk) disable iff (rst) opt_q.clk_sel && tmr_tick_q);
  c_wr_guard: cover property (@(posedge core_clk) disable iff (rst) status_wr && alu_flags);
endmodule

// [verification/tb_csr_core_regs.sv]
`timescale 1ns/10ps
module tb_csr_core_regs
  import csr_pkg::*;
();
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         por_event = 1'b0, wake_reset_event = 1'b0, wdt_timeout = 1'b0;
  logic         watchdog_clear_instr_exec = 1'b0, sleep_exec = 1'b0, file_wr = 1'b0;
  logic         option_load = 1'b0, tck_pin = 1'b0, tmr_tick_q, psa_wdt_q;
  csr_alu_req_t alu_req = '0;
  logic [7:0]   alu_result = 8'h00, file_addr = 8'h00, file_wdata = 8'h00, w_reg = 8'h00;
  logic [5:0]   dir_in = 6'h2b, wake_capable = 6'h1b, tck_pin_mask = 6'h04;
  logic [7:0]   status_q, tmr_ratio_q, wdt_ratio_q;
  logic [9:0]   page_base_q;
  logic [5:0]   wake_en_q, pullup_en_q, dir_eff_q;
  logic         ez, edc, ec;
  int           miscompares = 0;
  int           num_checks = 0;
  logic [4:0]   evs [7] = '{5'h01, 5'h04, 5'h02, 5'h06, 5'h05, 5'h08, 5'h10};
  logic [2:0]   exps [7] = '{3'b010, 3'b000, 3'b011, 3'b001, 3'b000, 3'b100, 3'b011};

  csr_core_regs dut (
    .core_clk, .rst, .por_event, .wake_reset_event, .wdt_timeout, .watchdog_clear_instr_exec,
    .sleep_exec, .alu_req, .alu_result, .file_wr, .file_addr, .file_wdata,
    .option_load, .w_reg, .dir_in, .wake_capable, .tck_pin_mask, .tck_pin,
    .status_q, .page_base_q, .wake_en_q, .pullup_en_q, .dir_eff_q, .tmr_tick_q,
    .psa_wdt_q, .tmr_ratio_q, .wdt_ratio_q
  );

  always #10 core_clk = ~core_clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic ev(input logic [4:0] e);
    @(posedge core_clk);
    {por_event, wake_reset_event, wdt_timeout, watchdog_clear_instr_exec, sleep_exec} <= e;
    @(posedge core_clk);
    {por_event, wake_reset_event, wdt_timeout, watchdog_clear_instr_exec, sleep_exec} <= 5'h00;
    tick(3);
  endtask

  task automatic opt(input logic [7:0] v);
    @(posedge core_clk);
    {option_load, w_reg} <= {1'b1, v};
    @(posedge core_clk);
    option_load <= 1'b0;
    tick(3);
  endtask

  task automatic chk_opt(input csr_option_t o);
    logic [5:0] act;
    act = wake_capable & dir_in;
    chk(wake_en_q, o.wake_n ? 6'h00 : act, "wake enable");
    chk(pullup_en_q, o.pullup_n ? 6'h00 : act, "pullup enable");
    chk(dir_eff_q, o.clk_sel ? dir_in | tck_pin_mask : dir_in, "pin direction");
    chk(psa_wdt_q, o.prescaler_assign, "prescaler owner");
    chk(tmr_ratio_q, (10'h2 << o.rate) - 10'h1, "timer ratio");
    chk(wdt_ratio_q, (10'h1 << o.rate) - 10'h1, "watchdog ratio");
    if (!o.clk_sel) chk(tmr_tick_q, 1'b1, "internal tick");
  endtask

  task automatic alu(input csr_alu_op_t op, input logic [7:0] a, b, input logic ci);
    logic [7:0] res;
    logic [8:0] s;
    logic [2:0] m;
    s = (op == CSR_OP_SUB) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    res = s[7:0];
    m = (op < CSR_OP_RRF) ? 3'b111 : 3'b011;
    case (op)
      CSR_OP_ADD: begin
        edc = (a[3:0] + b[3:0]) > 5'h0f;
        ec = s[8];
      end
      CSR_OP_SUB: begin
        edc = a[3:0] >= b[3:0];
        ec = a >= b;
      end
      CSR_OP_LOGIC: res = a & b;
      CSR_OP_RRF: begin
        res = {ci, a[7:1]};
        ec = a[0];
      end
      default: begin
        res = {a[6:0], ci};
        ec = a[7];
      end
    endcase
    if (op < CSR_OP_RRF) ez = (res == 8'h00);
    @(posedge core_clk);
    alu_req <= '{op, a, b, ci};
    alu_result <= res;
    @(posedge core_clk);
    alu_req.op <= CSR_OP_NONE;
    tick(3);
    chk(status_q[2:0] & m, {ez, edc, ec} & m, "alu flags");
  endtask

  task automatic wr(input logic [7:0] ad, d, input logic busy);
    @(posedge core_clk);
    {file_wr, file_addr, file_wdata} <= {1'b1, ad, d};
    if (busy) alu_req <= '{CSR_OP_LOGIC, 8'h01, 8'h01, 1'b0};
    if (busy) alu_result <= 8'h01;
    @(posedge core_clk);
    file_wr <= 1'b0;
    alu_req.op <= CSR_OP_NONE;
    tick(3);
  endtask

  task automatic pin(input logic lvl, input logic [9:0] n);
    logic [9:0] cnt;
    cnt = 10'h000;
    @(posedge core_clk);
    tck_pin <= lvl;
    repeat (8) begin
      tick(1);
      if (tmr_tick_q === 1'b1) cnt++;
    end
    chk(cnt, n, "external ticks");
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    tick(2);
    chk(status_q, 8'h18, "status after reset");
    chk(page_base_q, CSR_PAGE0_BASE, "page after reset");
    chk_opt(CSR_OPTION_RESET);
    $display("reset test done");
    alu(CSR_OP_ADD, 8'h0f, 8'h01, 1'b0);
    alu(CSR_OP_ADD, 8'hff, 8'h01, 1'b0);
    alu(CSR_OP_ADD, 8'h70, 8'h90, 1'b0);
    alu(CSR_OP_SUB, 8'h10, 8'h01, 1'b0);
    alu(CSR_OP_SUB, 8'h01, 8'h02, 1'b0);
    alu(CSR_OP_SUB, 8'h35, 8'h35, 1'b0);
    alu(CSR_OP_LOGIC, 8'h0f, 8'hf0, 1'b0);
    alu(CSR_OP_RRF, 8'h01, 8'h00, 1'b0);
    alu(CSR_OP_RLF, 8'h7e, 8'h00, 1'b1);
    $display("alu test done");
    for (int r = 0; r < 8; r++) begin
      opt({r[1], r[2], r[0], 1'b0, ~r[0], r[2:0]});
      chk_opt({r[1], r[2], r[0], 1'b0, ~r[0], r[2:0]});
    end
    opt(8'h20);
    pin(1'b1, 10'h001);
    pin(1'b0, 10'h000);
    opt(8'h30);
    pin(1'b1, 10'h000);
    pin(1'b0, 10'h001);
    opt(8'h00);
    @(posedge core_clk);
    dir_in <= 6'h00;
    tick(3);
    chk_opt(8'h00);
    @(posedge core_clk);
    dir_in <= 6'h2b;
    tick(3);
    $display("option test done");
    for (int i = 0; i < 7; i++) begin
      if (i == 6) opt(8'h00);
      ev(evs[i]);
      chk({status_q[7], (i == 5) ? 2'b00 : status_q[4:3]}, exps[i], "cause");
      if (i >= 5) chk(tmr_ratio_q, 10'h0ff, "option reset");
    end
    $display("event test done");
    ev(5'h01);
    wr(CSR_STATUS_ADDR, 8'hff, 1'b0);
    chk(status_q, 8'hb7, "status write ones");
    chk(page_base_q, CSR_PAGE1_BASE, "page one");
    ev(5'h04);
    wr(CSR_STATUS_ADDR, 8'h5f, 1'b0);
    chk(status_q, 8'h07, "status write mixed");
    chk(page_base_q, CSR_PAGE0_BASE, "page zero");
    wr(CSR_STATUS_ADDR, 8'h00, 1'b1);
    chk(status_q, 8'h03, "write during alu");
    wr(8'h04, 8'hff, 1'b0);
    chk(status_q, 8'h03, "other address");
    $display("status write test done");
    conclude();
  end
endmodule
